// >>> logic/cmp_dac_cfg.svh
// Offsets, field positions, reset values and timing for the comparator/DAC block
//
// Summary of operation
// - DAC is powered only while its power flag, bit 7 of control zero, is 1.
// - DAC pin drive flag routes the DAC level onto the DAC output pin.
// - Upper reference select: 00 supply, 01 external reference, 10 second buffer.
// - DAC level comes from the five-bit level field, reset to zero.
// - Unimplemented DAC register bits read zero and ignore writes.
// - Comparator-on flag runs the comparator; clearing it shuts it down.
// - Two-bit positive channel field picks pin, DAC, second buffer or ground.
// - With the comparator off, all its inputs are disconnected.
// - Three-bit negative channel field picks the inverting input source.
// - Result readable in control zero and in the shared result register.
// - Result drives its pin only when direction is output and comparator on.
// - Synchronized result copy goes to the ADC and the gated timer.
// - Unsynchronized result copy goes to the waveform unit.
// - Internal result latched once per instruction cycle; pin output unlatched.
`ifndef CMP_DAC_CFG_SVH
`define CMP_DAC_CFG_SVH
`define DAC_CTRL0_OFS   12'h000
`define DAC_LEVEL_OFS   12'h004
`define CMP_CTRL0_OFS   12'h008
`define CMP_CTRL1_OFS   12'h00c
`define CMP_SHARED_OFS  12'h010
`define PIN_CTRL_OFS    12'h014
`define DAC_POWER_BIT   7
`define DAC_DRIVE_BIT   5
`define DAC_REF_LSB     2
`define CMP_ON_BIT      7
`define CMP_RESULT_BIT  6
`define PIN_DIR_BIT     0
`define PIN_ANALOG_SELECT_BIT_BIT   1
`define CTRL_RESET      8'h00
`define PIN_RESET       2'h3
`define INSN_DIV        2'h3
`endif

// >>> logic/cmp_dac_pkg.sv
// Types for the comparator/DAC block
package cmp_dac_pkg;
    typedef enum logic [1:0] {
        REF_SUPPLY   = 2'h0,
        REF_EXT_PIN  = 2'h1,
        REF_FIXED    = 2'h2,
        REF_RESERVED = 2'h3
    } dac_ref_e;
    typedef enum logic [1:0] {
        POS_PIN    = 2'h0,
        POS_DAC    = 2'h1,
        POS_FIXED  = 2'h2,
        POS_GROUND = 2'h3
    } pos_chan_e;
    typedef enum logic [2:0] {
        NEG_PIN_A  = 3'h0,
        NEG_PIN_B  = 3'h1,
        NEG_DAC    = 3'h2,
        NEG_FIXED  = 3'h3,
        NEG_GROUND = 3'h4
    } neg_chan_e;
    typedef logic [7:0] level_t;
endpackage

// >>> logic/comparator_and_dac_control.sv
// Comparator and reference DAC control with APB registers
`timescale 1ns/1ps
`include "cmp_dac_cfg.svh"

module comparator_and_dac_control (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire cmp_dac_pkg::level_t supply_level,
    input  wire cmp_dac_pkg::level_t ext_ref_level,
    input  wire cmp_dac_pkg::level_t fixed_reference_second_buffer,
    input  wire cmp_dac_pkg::level_t positive_analog_pin,
    input  wire cmp_dac_pkg::level_t negative_pin_a,
    input  wire cmp_dac_pkg::level_t negative_pin_b,
    output cmp_dac_pkg::level_t      reference_dac_level,
    output cmp_dac_pkg::level_t      dac_output_pin,
    output logic                     dac_output_pin_oe,
    output logic                     dac_powered,
    output logic                     comparator_powered,
    output logic                     positive_input_connected,
    output logic                     negative_input_connected,
    output logic                     result_synchronized,
    output logic                     result_unsynchronized,
    output logic                     comparator_pin_out,
    output logic                     comparator_pin_oe,
    output logic                     analog_select_bit
);

    logic [7:0]  dac_control_zero_q;
    logic [4:0]  dac_level_field_q;
    logic        comparator_on_flag_q;
    logic [2:0]  negative_channel_field_q;
    logic [1:0]  positive_channel_field_q;
    logic        pin_direction_bit_q;
    logic        analog_select_q;
    logic [1:0]  insn_cnt_q;
    logic        insn_tick;
    logic        result_latch_q;
    logic        setup;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_d;
    logic        dac_power_flag;
    logic        dac_pin_drive_flag;
    logic [1:0]  dac_upper_ref_select;
    logic [7:0]  upper_ref;
    logic [12:0] dac_product;
    logic [7:0]  dac_level_d;
    logic [7:0]  pos_level;
    logic [7:0]  neg_level;
    logic        compare_raw;
    logic        shared_result_bit;
    logic        wr_dac_ctrl0;
    logic        wr_dac_level;
    logic        wr_cmp_ctrl0;
    logic        wr_cmp_ctrl1;
    logic        wr_pin_ctrl;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;

    // Per-register write strobes, high only in the committing access cycle
    assign wr_dac_ctrl0 = wr_en & (paddr == `DAC_CTRL0_OFS);
    assign wr_dac_level = wr_en & (paddr == `DAC_LEVEL_OFS);
    assign wr_cmp_ctrl0 = wr_en & (paddr == `CMP_CTRL0_OFS);
    assign wr_cmp_ctrl1 = wr_en & (paddr == `CMP_CTRL1_OFS);
    assign wr_pin_ctrl  = wr_en & (paddr == `PIN_CTRL_OFS);

    assign dac_power_flag       = dac_control_zero_q[`DAC_POWER_BIT];
    assign dac_pin_drive_flag   = dac_control_zero_q[`DAC_DRIVE_BIT];
    assign dac_upper_ref_select = dac_control_zero_q[`DAC_REF_LSB +: 2];

    // Address decode
    always_comb begin
        case (paddr)
            `DAC_CTRL0_OFS, `DAC_LEVEL_OFS, `CMP_CTRL0_OFS,
            `CMP_CTRL1_OFS, `CMP_SHARED_OFS, `PIN_CTRL_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux
    always_comb begin
        rd_d = 32'h0;
        case (paddr)
            `DAC_CTRL0_OFS: begin
                rd_d[7:0] = dac_control_zero_q;
            end
            `DAC_LEVEL_OFS: begin
                rd_d[4:0] = dac_level_field_q;
            end
            `CMP_CTRL0_OFS: begin
                rd_d[`CMP_ON_BIT] = comparator_on_flag_q;
                rd_d[`CMP_RESULT_BIT] = result_latch_q;
                rd_d[2:0] = negative_channel_field_q;
            end
            `CMP_CTRL1_OFS: begin
                rd_d[1:0] = positive_channel_field_q;
            end
            `CMP_SHARED_OFS: begin
                rd_d[0] = shared_result_bit;
            end
            `PIN_CTRL_OFS: begin
                rd_d[`PIN_DIR_BIT] = pin_direction_bit_q;
                rd_d[`PIN_ANALOG_SELECT_BIT_BIT] = analog_select_q;
            end
            default: begin
                rd_d = 32'h0;
            end
        endcase
    end

    assign shared_result_bit = result_latch_q;

    // Bus answer one access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            // Unmapped offsets answer with an error and have no effect
            pslverr <= setup & ~mapped;
        end
    end

    // Read data captured at setup, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= rd_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_control_zero_q <= `CTRL_RESET;
        end else if (wr_dac_ctrl0) begin
            dac_control_zero_q <= pwdata[7:0] & 8'hac;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_level_field_q <= 5'h00;
        end else if (wr_dac_level) begin
            dac_level_field_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_on_flag_q     <= 1'b0;
            negative_channel_field_q <= 3'h0;
        end else if (wr_cmp_ctrl0) begin
            // Result bit is read-only, its write data is dropped
            comparator_on_flag_q     <= pwdata[`CMP_ON_BIT];
            negative_channel_field_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            positive_channel_field_q <= 2'h0;
        end else if (wr_cmp_ctrl1) begin
            positive_channel_field_q <= pwdata[1:0];
        end
    end

    // Pin direction, reset to input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_direction_bit_q <= 1'b1;
        end else if (wr_pin_ctrl) begin
            pin_direction_bit_q <= pwdata[`PIN_DIR_BIT];
        end
    end

    // Analog select, reset to analog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_select_q <= 1'b1;
        end else if (wr_pin_ctrl) begin
            analog_select_q <= pwdata[`PIN_ANALOG_SELECT_BIT_BIT];
        end
    end

    always_comb begin
        case (dac_upper_ref_select)
            cmp_dac_pkg::REF_SUPPLY:  upper_ref = supply_level;
            cmp_dac_pkg::REF_EXT_PIN: upper_ref = ext_ref_level;
            cmp_dac_pkg::REF_FIXED:   upper_ref = fixed_reference_second_buffer;
            default:                  upper_ref = 8'h00;
        endcase
    end

    // level scaled by field over 32
    assign dac_product = 13'(upper_ref * dac_level_field_q);
    assign dac_level_d = dac_power_flag ? dac_product[12:5] : 8'h00;

    always_comb begin
        case (positive_channel_field_q)
            cmp_dac_pkg::POS_PIN:   pos_level = positive_analog_pin;
            cmp_dac_pkg::POS_DAC:   pos_level = dac_level_d;
            cmp_dac_pkg::POS_FIXED: pos_level = fixed_reference_second_buffer;
            default:                pos_level = 8'h00;
        endcase
    end

    always_comb begin
        case (negative_channel_field_q)
            cmp_dac_pkg::NEG_PIN_A: neg_level = negative_pin_a;
            cmp_dac_pkg::NEG_PIN_B: neg_level = negative_pin_b;
            cmp_dac_pkg::NEG_DAC:   neg_level = dac_level_d;
            cmp_dac_pkg::NEG_FIXED: neg_level = fixed_reference_second_buffer;
            default:                neg_level = 8'h00;
        endcase
    end

    assign compare_raw = comparator_on_flag_q & (pos_level > neg_level);

    // Instruction cycle divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insn_cnt_q <= 2'h0;
        end else begin
            insn_cnt_q <= insn_cnt_q + 2'h1;
        end
    end

    assign insn_tick = (insn_cnt_q == `INSN_DIV);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_latch_q <= 1'b0;
        end else if (insn_tick) begin
            result_latch_q <= compare_raw;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_powered         <= 1'b0;
            reference_dac_level <= 8'h00;
        end else begin
            dac_powered         <= dac_power_flag;
            // Level already forced to zero while unpowered
            reference_dac_level <= dac_level_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_output_pin    <= 8'h00;
            dac_output_pin_oe <= 1'b0;
        end else begin
            // Released pin shows zero, never a stale level
            dac_output_pin    <= dac_pin_drive_flag ? dac_level_d : 8'h00;
            dac_output_pin_oe <= dac_pin_drive_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_powered <= 1'b0;
        end else begin
            comparator_powered <= comparator_on_flag_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            positive_input_connected <= 1'b0;
            negative_input_connected <= 1'b0;
        end else begin
            positive_input_connected <= comparator_on_flag_q;
            negative_input_connected <= comparator_on_flag_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_synchronized <= 1'b0;
        end else begin
            result_synchronized <= result_latch_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_unsynchronized <= 1'b0;
        end else begin
            result_unsynchronized <= compare_raw;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_pin_out <= 1'b0;
            comparator_pin_oe  <= 1'b0;
        end else begin
            // Data follows the raw compare, only the enable is gated
            comparator_pin_out <= compare_raw;
            comparator_pin_oe  <= ~pin_direction_bit_q & comparator_on_flag_q;
        end
    end

    // Analog select mirrored for the pad
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_select_bit <= 1'b1;
        end else begin
            analog_select_bit <= analog_select_q;
        end
    end

endmodule

// >>> tb/cmp_dac_checker.sv
// Port assertions for the comparator/DAC block
`timescale 1ns/1ps
module cmp_dac_checker (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire cmp_dac_pkg::level_t reference_dac_level,
    input wire cmp_dac_pkg::level_t dac_output_pin,
    input wire logic                dac_output_pin_oe,
    input wire logic                dac_powered,
    input wire logic                comparator_powered,
    input wire logic                positive_input_connected,
    input wire logic                negative_input_connected,
    input wire logic                result_synchronized,
    input wire logic                result_unsynchronized,
    input wire logic                comparator_pin_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_one_pulse: assert property (s_setup |=> s_answer) else $error("pready not one pulse");
    a_dac_off_zero: assert property (!dac_powered |-> reference_dac_level == 8'h00)
        else $error("level while dac off");
    a_pin_released: assert property (!dac_output_pin_oe |-> dac_output_pin == 8'h00)
        else $error("dac pin driven while released");
    a_inputs_off: assert property (!comparator_powered |-> !positive_input_connected && !negative_input_connected)
        else $error("input connected while off");
    a_inputs_on: assert property (comparator_powered |-> positive_input_connected && negative_input_connected)
        else $error("input open while on");
    a_pin_needs_on: assert property (comparator_pin_oe |-> comparator_powered)
        else $error("pin driven while off");
    a_async_off: assert property (!comparator_powered [*3] |-> !result_unsynchronized)
        else $error("raw result while off");
    a_sync_off: assert property (!comparator_powered [*8] |-> !result_synchronized)
        else $error("sync result while off");
    a_sync_hold: assert property ($changed(result_synchronized) |=> $stable(result_synchronized) [*3])
        else $error("sync result changed inside cycle");
endmodule
bind comparator_and_dac_control cmp_dac_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .reference_dac_level(reference_dac_level), .dac_output_pin(dac_output_pin),
    .dac_output_pin_oe(dac_output_pin_oe), .dac_powered(dac_powered), .comparator_powered(comparator_powered),
    .positive_input_connected(positive_input_connected), .negative_input_connected(negative_input_connected),
    .result_synchronized(result_synchronized), .result_unsynchronized(result_unsynchronized),
    .comparator_pin_oe(comparator_pin_oe));

// >>> tb/analog_source_model.sv
// Fixed stand-in levels for the analog sources
`timescale 1ns/1ps
module analog_source_model (
    output cmp_dac_pkg::level_t supply_level,
    output cmp_dac_pkg::level_t ext_ref_level,
    output cmp_dac_pkg::level_t fixed_level,
    output cmp_dac_pkg::level_t pos_pin,
    output cmp_dac_pkg::level_t neg_a,
    output cmp_dac_pkg::level_t neg_b
);
    assign supply_level  = 8'hc8;
    assign ext_ref_level = 8'h64;
    assign fixed_level   = 8'h3c;
    assign pos_pin       = 8'h96;
    assign neg_a         = 8'h64;
    assign neg_b         = 8'hb4;
endmodule

// >>> tb/comparator_and_dac_control_bench.sv
// Self-checking bench for the comparator/DAC block
`timescale 1ns/1ps
`include "cmp_dac_cfg.svh"
module comparator_and_dac_control_bench;
    logic                pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0]         paddr = 12'h0;
    logic [31:0]         pwdata = 32'h0, prdata, r;
    logic                pready, pslverr, e, dpwr, doe, cpwr, pcon, ncon, rs, ra, cpin, coe, asel;
    cmp_dac_pkg::level_t sup, ext, fix, pp, pa, pb, dlvl, dpin;
    int                  n_errors = 0, n_checks = 0;
    always #10 pclk = ~pclk;
    analog_source_model src (.supply_level(sup), .ext_ref_level(ext), .fixed_level(fix), .pos_pin(pp),
        .neg_a(pa), .neg_b(pb));
    comparator_and_dac_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_level(sup), .ext_ref_level(ext), .fixed_reference_second_buffer(fix), .positive_analog_pin(pp),
        .negative_pin_a(pa), .negative_pin_b(pb), .reference_dac_level(dlvl), .dac_output_pin(dpin),
        .dac_output_pin_oe(doe), .dac_powered(dpwr), .comparator_powered(cpwr), .positive_input_connected(pcon),
        .negative_input_connected(ncon), .result_synchronized(rs), .result_unsynchronized(ra),
        .comparator_pin_out(cpin), .comparator_pin_oe(coe), .analog_select_bit(asel));
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            n_errors++;
            $display("MISMATCH %0t apb answer timeout", $time);
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'h0, a, 32'h0);
        chk(r, exp, what);
    endtask
    task automatic t_reset();
        rd(`DAC_LEVEL_OFS, 32'h0, "level reset");
        rd(`DAC_CTRL0_OFS, 32'h0, "dac0 reset");
        rd(`PIN_CTRL_OFS, 32'h3, "pin reset");
        chk(asel, 1'h1, "asel reset");
    endtask
    task automatic t_dac();
        logic [7:0] lv[3] = '{8'hc8, 8'h64, 8'h3c};
        logic [7:0] x;
        apb(1'h1, `DAC_LEVEL_OFS, 32'hff);
        rd(`DAC_LEVEL_OFS, 32'h1f, "level mask");
        for (int c = 0; c < 4; c++) begin
            x = (c == 3) ? 8'h0 : 8'((int'(lv[c]) * 31) >> 5);
            apb(1'h1, `DAC_CTRL0_OFS, 32'hf3 | 32'(c << 2));
            rd(`DAC_CTRL0_OFS, 32'ha0 | 32'(c << 2), "dac0 mask");
            chk({dlvl, dpin}, {x, x}, "dac level");
            chk({dpwr, doe}, 2'h3, "dac on");
        end
        apb(1'h1, `DAC_CTRL0_OFS, 32'h80);
        repeat (2) @(posedge pclk);
        chk({doe, dpin}, 9'h0, "pin off");
        apb(1'h1, `DAC_CTRL0_OFS, 32'h20);
        repeat (2) @(posedge pclk);
        chk({dpwr, dlvl}, 9'h0, "dac off");
        apb(1'h1, `DAC_CTRL0_OFS, 32'h80);
    endtask
    task automatic t_unmapped();
        apb(1'h1, 12'h018, 32'hff);
        chk(e, 1'h1, "err write");
        rd(12'h018, 32'h0, "unmapped read");
        chk(e, 1'h1, "err read");
    endtask
    task automatic t_cmp();
        int   p[9] = '{0, 1, 2, 3, 0, 0, 0, 0, 0};
        int   n[9] = '{0, 0, 0, 0, 1, 2, 3, 4, 7};
        logic x[9] = '{1, 1, 0, 0, 0, 0, 1, 1, 1};
        for (int i = 0; i < 9; i++) begin
            apb(1'h1, `CMP_CTRL1_OFS, 32'(p[i]));
            apb(1'h1, `CMP_CTRL0_OFS, 32'h80 | 32'(n[i]));
            repeat (8) @(posedge pclk);
            chk({rs, ra}, {x[i], x[i]}, "result");
            rd(`CMP_CTRL0_OFS, {24'h0, 1'h1, x[i], 3'h0, 3'(n[i])}, "status bit");
            rd(`CMP_SHARED_OFS, 32'(x[i]), "shared bit");
            chk({cpwr, pcon, ncon, coe}, 4'he, "on, pin input");
        end
        apb(1'h1, `PIN_CTRL_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk({coe, cpin, asel}, 3'h6, "pin drive");
        apb(1'h1, `CMP_CTRL0_OFS, 32'h0);
        repeat (8) @(posedge pclk);
        chk({cpwr, pcon, ncon, coe, rs, ra}, 6'h0, "off");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_dac();
        t_unmapped();
        t_cmp();
        give_verdict();
    end
endmodule
